// ### ienc_top.sv
// Incremental encoder interface with index latch and clear-on-read status.
// Assumes encoder pins asynchronous, register port synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module ienc_top
   import ienc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        enc_a,
   input  wire logic        enc_b,
   input  wire logic        enc_n,
   input  wire logic [31:0] ramp_current_position,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [6:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   output logic             irq_source_flag
);
   logic [2:0]  s1_ff;
   logic [2:0]  s2_ff;
   logic [2:0]  prev_ff;
   logic [15:0] mode_ff;
   logic [31:0] const_ff;
   logic [31:0] latch_ff;
   logic [31:0] ramp_latch_ff;
   logic        armed_ff;
   logic        flag_ff;
   logic [31:0] pos;
   logic        a;
   logic        b;
   logic        n_act;
   logic        n_act_prev;
   logic        phase_ok;
   logic        n_trig;
   logic        event_q;
   logic        capture;
   logic        step;
   logic        dir_up;
   logic        pos_wr;
   logic        mode_wr;

   // Two-stage synchronisers for A, B, N
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_ff   <= 3'h0;
         s2_ff   <= 3'h0;
         prev_ff <= 3'h0;
      end else begin
         s1_ff   <= {enc_n, enc_b, enc_a};
         s2_ff   <= s1_ff;
         prev_ff <= s2_ff;
      end
   end

   assign a          = s2_ff[0];
   assign b          = s2_ff[1];
   assign n_act      = s2_ff[2] == mode_ff[MODE_POL_N];
   assign n_act_prev = prev_ff[2] == mode_ff[MODE_POL_N];
   assign phase_ok   = mode_ff[MODE_SKIP_AB] ||
                       ((a == mode_ff[MODE_POL_A]) &&
                        (b == mode_ff[MODE_POL_B]));

   // Sensitivity selection
   always_comb begin
      unique case (mode_ff[MODE_EDGE_HI:MODE_EDGE_LO])
         SENS_LEVEL: n_trig = n_act;
         SENS_RISE:  n_trig = n_act && !n_act_prev;
         SENS_FALL:  n_trig = !n_act && n_act_prev;
         SENS_BOTH:  n_trig = n_act != n_act_prev;
      endcase
   end

   assign event_q = n_trig && phase_ok;
   assign capture = event_q && (mode_ff[MODE_CLR_CONT] ||
                                (mode_ff[MODE_CLR_ONCE] && armed_ff));

   // Quadrature decode: Gray transition of {A,B}
   assign step   = (s2_ff[0] ^ prev_ff[0]) ^ (s2_ff[1] ^ prev_ff[1]);
   assign dir_up = s2_ff[0] ^ prev_ff[1];

   assign pos_wr  = reg_wr && reg_addr == REG_POS_WRITE;
   assign mode_wr = reg_wr && reg_addr == REG_MODE;

   ienc_accum u_accum (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .step      (step),
      .dir_up    (dir_up),
      .acc_const (const_ff),
      .decimal   (mode_ff[MODE_DECIMAL]),
      .load      (pos_wr || (capture && mode_ff[MODE_CLR_POS])),
      .load_val  (pos_wr ? reg_wdata : 32'h0000_0000),
      .pos_ff    (pos)
   );

   // Configuration registers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_ff  <= MODE_RESET;
         const_ff <= CONST_RESET;
      end else begin
         if (mode_wr)
            mode_ff <= reg_wdata[15:0] & MODE_WMASK;
         if (reg_wr && reg_addr == REG_CONST)
            const_ff <= reg_wdata;
      end
   end

   // One-shot arming
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         armed_ff <= 1'b0;
      else if (mode_wr)
         armed_ff <= reg_wdata[MODE_CLR_ONCE];
      else if (capture)
         armed_ff <= 1'b0;
   end

   // Latches
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         latch_ff      <= 32'h0000_0000;
         ramp_latch_ff <= 32'h0000_0000;
      end else if (capture) begin
         latch_ff <= pos;
         if (mode_ff[MODE_LATCH_RAMP])
            ramp_latch_ff <= ramp_current_position;
      end
   end

   // Event flag: set wins over read clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         flag_ff <= 1'b0;
      else if (event_q)
         flag_ff <= 1'b1;
      else if (reg_rd && reg_addr == REG_STATUS)
         flag_ff <= 1'b0;
   end

   assign irq_source_flag = flag_ff;

   // Read data
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd) begin
         unique case (reg_addr)
            REG_MODE:       reg_rdata <= {16'h0000, mode_ff};
            REG_STATUS:     reg_rdata <= {31'h0000_0000, flag_ff};
            REG_POS_WRITE:  reg_rdata <= pos;
            REG_POS_READ:   reg_rdata <= pos;
            REG_CONST:      reg_rdata <= const_ff;
            REG_LATCH:      reg_rdata <= latch_ff;
            REG_RAMP_LATCH: reg_rdata <= ramp_latch_ff;
            default:        reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   // Checker helpers
   logic [1:0] sens_sel;
   logic [1:0] cap_cnt_ff;

   assign sens_sel = mode_ff[MODE_EDGE_HI:MODE_EDGE_LO];

   // Captures since the last mode write
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         cap_cnt_ff <= 2'h0;
      else if (mode_wr)
         cap_cnt_ff <= 2'h0;
      else if (capture && cap_cnt_ff != 2'h3)
         cap_cnt_ff <= cap_cnt_ff + 2'h1;
   end

   // Pin movement seen through the synchroniser
   sequence s_index_moves;
      s1_ff[2] != s2_ff[2];
   endsequence

   sequence s_index_edge;
      s2_ff[2] != prev_ff[2];
   endsequence

   sequence s_index_still;
      s2_ff[2] == prev_ff[2];
   endsequence

   sequence s_phase_moves;
      (a != prev_ff[0]) || (b != prev_ff[1]);
   endsequence

   a_status_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      event_q |=> flag_ff)
      else $error("Flag not set");

   a_status_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      reg_rd && reg_addr == REG_STATUS && !event_q |=> !flag_ff)
      else $error("Flag not cleared");

   a_status_read: assert property (@(posedge core_clk) disable iff (sys_rst)
      reg_rd && reg_addr == REG_STATUS |=> reg_rdata == {31'h0000_0000, $past(flag_ff)})
      else $error("Status read wrong");

   a_irq_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
      event_q |=> irq_source_flag)
      else $error("Interrupt source missed");

   a_latch_pos: assert property (@(posedge core_clk) disable iff (sys_rst)
      capture |=> latch_ff == $past(pos))
      else $error("Latch wrong");

   a_latch_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      !capture |=> $stable(latch_ff))
      else $error("Latch moved");

   a_clear_pos: assert property (@(posedge core_clk) disable iff (sys_rst)
      capture && mode_ff[MODE_CLR_POS] && !pos_wr |=> pos == 32'h0000_0000)
      else $error("Position not cleared");

   a_once_only: assert property (@(posedge core_clk) disable iff (sys_rst)
      capture && !mode_ff[MODE_CLR_CONT] && !mode_wr |=> !armed_ff)
      else $error("One-shot rearmed");

   a_once_count: assert property (@(posedge core_clk) disable iff (sys_rst)
      mode_ff[MODE_CLR_ONCE] && !mode_ff[MODE_CLR_CONT] |-> cap_cnt_ff <= 2'h1)
      else $error("One-shot captured twice");

   a_cont_every: assert property (@(posedge core_clk) disable iff (sys_rst)
      event_q && mode_ff[MODE_CLR_CONT] |-> capture)
      else $error("Continuous capture missed");

   a_pos_write: assert property (@(posedge core_clk) disable iff (sys_rst)
      pos_wr |=> pos == $past(reg_wdata))
      else $error("Write lost");

   a_pos_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
      !step && !pos_wr && !(capture && mode_ff[MODE_CLR_POS]) |=> $stable(pos))
      else $error("Position drifted");

   a_unit_up: assert property (@(posedge core_clk) disable iff (sys_rst)
      step && dir_up && !pos_wr && !(capture && mode_ff[MODE_CLR_POS])
      && !mode_ff[MODE_DECIMAL] && const_ff == CONST_RESET |=> pos == $past(pos) + 32'h0000_0001)
      else $error("Unit step up wrong");

   a_unit_down: assert property (@(posedge core_clk) disable iff (sys_rst)
      step && !dir_up && !pos_wr && !(capture && mode_ff[MODE_CLR_POS])
      && !mode_ff[MODE_DECIMAL] && const_ff == CONST_RESET |=> pos == $past(pos) - 32'h0000_0001)
      else $error("Unit step down wrong");

   a_reserved_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      mode_ff[15:11] == 5'h00)
      else $error("Reserved bits set");

   a_mode_read: assert property (@(posedge core_clk) disable iff (sys_rst)
      reg_rd && reg_addr == REG_MODE |=> reg_rdata[31:11] == 21'h000000)
      else $error("Reserved bits read back");

   a_phase_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      event_q && !mode_ff[MODE_SKIP_AB] |-> a == mode_ff[MODE_POL_A] && b == mode_ff[MODE_POL_B])
      else $error("Phase check bypassed");

   a_skip_any: assert property (@(posedge core_clk) disable iff (sys_rst)
      mode_ff[MODE_SKIP_AB] && n_trig |-> event_q)
      else $error("Skipped phase check blocked");

   a_pol_a_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      !mode_ff[MODE_SKIP_AB] && a != mode_ff[MODE_POL_A] |-> !event_q)
      else $error("A level not required");

   a_pol_b_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      !mode_ff[MODE_SKIP_AB] && b != mode_ff[MODE_POL_B] |-> !event_q)
      else $error("B level not required");

   a_pol_n_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      event_q && sens_sel == SENS_LEVEL |-> s2_ff[2] == mode_ff[MODE_POL_N])
      else $error("Index level wrong");

   a_sync_ladder: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_index_moves |=> s_index_edge)
      else $error("Index sync broken");

   a_edge_needed: assert property (@(posedge core_clk) disable iff (sys_rst)
      (sens_sel != SENS_LEVEL) ##0 s_index_still |-> !event_q)
      else $error("Edge event without edge");

   a_rise_only: assert property (@(posedge core_clk) disable iff (sys_rst)
      n_trig && sens_sel == SENS_RISE |-> s2_ff[2] == mode_ff[MODE_POL_N])
      else $error("Rise event on wrong edge");

   a_fall_only: assert property (@(posedge core_clk) disable iff (sys_rst)
      n_trig && sens_sel == SENS_FALL |-> s2_ff[2] != mode_ff[MODE_POL_N])
      else $error("Fall event on wrong edge");

   a_level_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      sens_sel == SENS_LEVEL && n_act && phase_ok |-> event_q)
      else $error("Level event missed");

   a_ramp_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      !capture |=> $stable(ramp_latch_ff))
      else $error("Ramp latch moved");

   a_ramp_take: assert property (@(posedge core_clk) disable iff (sys_rst)
      capture && mode_ff[MODE_LATCH_RAMP] |=> ramp_latch_ff == $past(ramp_current_position))
      else $error("Ramp position not taken");

   a_ramp_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      capture && !mode_ff[MODE_LATCH_RAMP] |=> $stable(ramp_latch_ff))
      else $error("Ramp latch taken while off");

   a_step_move: assert property (@(posedge core_clk) disable iff (sys_rst)
      step |-> s_phase_moves)
      else $error("Step without phase change");

   a_double_move: assert property (@(posedge core_clk) disable iff (sys_rst)
      (a != prev_ff[0]) && (b != prev_ff[1]) |-> !step)
      else $error("Step on double change");
endmodule
`default_nettype wire

// ### ienc_pkg.sv
// Incremental encoder block: register indices, field positions, reset values.
// Assumes a register port carrying word indices and 32-bit data.
package ienc_pkg;
   localparam logic [6:0]  REG_MODE        = 7'h00;
   localparam logic [6:0]  REG_STATUS      = 7'h01;
   localparam logic [6:0]  REG_POS_WRITE   = 7'h02;
   localparam logic [6:0]  REG_POS_READ    = 7'h03;
   localparam logic [6:0]  REG_CONST       = 7'h04;
   localparam logic [6:0]  REG_LATCH       = 7'h05;
   localparam logic [6:0]  REG_RAMP_LATCH  = 7'h3d;
   localparam int          MODE_POL_A      = 0;
   localparam int          MODE_POL_B      = 1;
   localparam int          MODE_POL_N      = 2;
   localparam int          MODE_SKIP_AB    = 3;
   localparam int          MODE_CLR_CONT   = 4;
   localparam int          MODE_CLR_ONCE   = 5;
   localparam int          MODE_EDGE_LO    = 6;
   localparam int          MODE_EDGE_HI    = 7;
   localparam int          MODE_CLR_POS    = 8;
   localparam int          MODE_LATCH_RAMP = 9;
   localparam int          MODE_DECIMAL    = 10;
   localparam logic [15:0] MODE_WMASK      = 16'h07ff;
   localparam logic [15:0] MODE_RESET      = 16'h0000;
   localparam logic [31:0] CONST_RESET     = 32'h0001_0000;
   localparam logic [16:0] DIV_BINARY      = 17'h10000;
   localparam logic [16:0] DIV_DECIMAL     = 17'h02710;
   localparam logic [1:0]  SENS_LEVEL      = 2'h0;
   localparam logic [1:0]  SENS_RISE       = 2'h1;
   localparam logic [1:0]  SENS_FALL       = 2'h2;
   localparam logic [1:0]  SENS_BOTH       = 2'h3;
endpackage

// ### ienc_accum.sv
// Encoder position accumulator with fractional remainder.
// Assumes step pulses from the quadrature decoder on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ienc_accum
   import ienc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        step,
   input  wire logic        dir_up,
   input  wire logic [31:0] acc_const,
   input  wire logic        decimal,
   input  wire logic        load,
   input  wire logic [31:0] load_val,
   output logic      [31:0] pos_ff
);
   logic        [16:0] frac_ff;
   logic        [16:0] div;
   logic        [15:0] cint;
   logic        [16:0] cfrac;
   logic signed [17:0] fsum;
   logic signed [31:0] isum;
   logic        [16:0] nxt_frac;

   assign div   = decimal ? DIV_DECIMAL : DIV_BINARY;
   assign cint  = acc_const[31] ? 16'(-acc_const[31:16] - 16'(acc_const[15:0] != 16'h0000))
                                : acc_const[31:16];
   assign cfrac = {1'b0, acc_const[31] ? 16'(-acc_const[15:0]) : acc_const[15:0]};

   // Magnitude step with carry from fractional remainder
   always_comb begin
      fsum     = dir_up ^ acc_const[31] ? 18'(signed'({1'b0, frac_ff})) + 18'(signed'({1'b0, cfrac}))
                                        : 18'(signed'({1'b0, frac_ff})) - 18'(signed'({1'b0, cfrac}));
      isum     = 32'(signed'({1'b0, cint}));
      nxt_frac = fsum[16:0];
      if (fsum >= 18'(signed'({1'b0, div}))) begin
         nxt_frac = 17'(fsum - 18'(signed'({1'b0, div})));
         isum     = isum + 32'sd1;
      end else if (fsum < 18'sd0) begin
         nxt_frac = 17'(fsum + 18'(signed'({1'b0, div})));
         isum     = isum + 32'sd1;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pos_ff  <= 32'h0000_0000;
         frac_ff <= 17'h00000;
      end else if (load) begin
         pos_ff  <= load_val;
         frac_ff <= 17'h00000;
      end else if (step) begin
         pos_ff  <= (dir_up ^ acc_const[31]) ? pos_ff + isum : pos_ff - isum;
         frac_ff <= nxt_frac;
      end
   end
endmodule
`default_nettype wire

// ### ienc_enc_model.sv
// Quadrature encoder model with an index channel.
// Assumes calls from the bench; pins move on rising core_clk.
`timescale 1ns/1ps
`default_nettype none
module ienc_enc_model (
   input  wire logic core_clk,
   output logic      enc_a,
   output var logic  enc_b,
   output var logic  enc_n
);
   logic [1:0] ph_ff;
   initial begin
      ph_ff = 2'h0;
      enc_n = 1'b0;
   end
   // Gray order 00,10,11,01 on A,B: A leads when counting up
   assign enc_a = ph_ff[0] ^ ph_ff[1];
   assign enc_b = ph_ff[1];
   task automatic move(input int n, input bit up);
      repeat (n) begin
         @(posedge core_clk);
         ph_ff <= up ? ph_ff + 2'h1 : ph_ff - 2'h1;
         repeat (4) @(posedge core_clk);
      end
   endtask
   task automatic index(input bit lvl);
      @(posedge core_clk);
      enc_n <= lvl;
      repeat (6) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// ### ienc_top_tb.sv
// Testbench for the encoder block: register tasks and directed checks.
// Assumes the package, design and encoder model compiled first.
`timescale 1ns/1ps
`default_nettype none
module ienc_top_tb
   import ienc_pkg::*;
;
   logic        core_clk;
   logic        sys_rst;
   logic        reg_wr;
   logic        reg_rd;
   logic [6:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] ramp_pos;
   logic [31:0] reg_rdata;
   logic        irq_flag;
   logic        enc_a;
   logic        enc_b;
   logic        enc_n;
   logic [31:0] v;
   logic [15:0] qmode [4] = '{16'h0046, 16'h0045, 16'h0047, 16'h004e};
   logic        qexp [4]  = '{1'b0, 1'b0, 1'b1, 1'b1};
   int          n_errors   = 0;
   int          n_compared = 0;
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   ienc_top ienc_top_inst (
      .core_clk(core_clk), .sys_rst(sys_rst), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n),
      .ramp_current_position(ramp_pos), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .irq_source_flag(irq_flag)
   );
   ienc_enc_model ienc_enc_model_inst (
      .core_clk(core_clk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n)
   );
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      #1 d = reg_rdata;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task automatic rdc(input string nm, input logic [6:0] a, input logic [31:0] exp);
      rd(a, v);
      chk(nm, v, exp);
   endtask
   task automatic pulse;
      ienc_enc_model_inst.index(1'b1);
      ienc_enc_model_inst.index(1'b0);
   endtask
   task automatic mv(input int n, input bit up);
      ienc_enc_model_inst.move(n, up);
   endtask
   task automatic test_done;
      if (n_errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      sys_rst   = 1'b1;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 7'h00;
      reg_wdata = 32'h0000_0000;
      ramp_pos  = 32'h0000_0000;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      rdc("mode", REG_MODE, {16'h0, MODE_RESET});
      rdc("const", REG_CONST, CONST_RESET);
      rdc("position", REG_POS_READ, 32'h0);
      wr(REG_MODE, 32'h0000_ffff);
      rdc("mode mask", REG_MODE, 32'h0000_07ff);
      wr(REG_MODE, 32'h0);
      mv(4, 1'b1);
      mv(2, 1'b0);
      rdc("position", REG_POS_READ, 32'h2);
      rdc("position wr", REG_POS_WRITE, 32'h2);
      for (int i = 0; i < 4; i++) begin
         wr(REG_MODE, {16'h0, qmode[i]});
         rd(REG_STATUS, v);
         pulse();
         rdc("qualify", REG_STATUS, {31'h0, qexp[i]});
      end
      wr(REG_MODE, 32'h0000_015c);
      rd(REG_STATUS, v);
      ienc_enc_model_inst.index(1'b1);
      chk("irq", {31'h0, irq_flag}, 32'h1);
      ienc_enc_model_inst.index(1'b0);
      rdc("latch", REG_LATCH, 32'h2);
      rdc("cleared", REG_POS_READ, 32'h0);
      rdc("status", REG_STATUS, 32'h1);
      rdc("status", REG_STATUS, 32'h0);
      chk("irq", {31'h0, irq_flag}, 32'h0);
      mv(1, 1'b1);
      pulse();
      rdc("latch cont", REG_LATCH, 32'h1);
      rdc("cleared cont", REG_POS_READ, 32'h0);
      @(posedge core_clk);
      ramp_pos <= 32'h1234_5678;
      wr(REG_MODE, 32'h0000_026c);
      mv(3, 1'b1);
      pulse();
      @(posedge core_clk);
      ramp_pos <= 32'h0000_abcd;
      mv(1, 1'b1);
      pulse();
      rdc("latch once", REG_LATCH, 32'h3);
      rdc("ramp latch", REG_RAMP_LATCH, 32'h1234_5678);
      rdc("position", REG_POS_READ, 32'h4);
      for (int s = 0; s < 4; s++) begin
         wr(REG_MODE, {24'h0, s[1:0], 6'h0c});
         rd(REG_STATUS, v);
         ienc_enc_model_inst.index(1'b1);
         rdc("rise", REG_STATUS, {31'h0, s != 2});
         ienc_enc_model_inst.index(1'b0);
         rdc("fall", REG_STATUS, {31'h0, s != 1});
      end
      wr(REG_MODE, 32'h0000_0048);
      rd(REG_STATUS, v);
      ienc_enc_model_inst.index(1'b1);
      rdc("active low", REG_STATUS, 32'h0);
      ienc_enc_model_inst.index(1'b0);
      rdc("active low", REG_STATUS, 32'h1);
      wr(REG_CONST, 32'h0001_8000);
      wr(REG_POS_WRITE, 32'h0);
      mv(2, 1'b1);
      rdc("binary", REG_POS_READ, 32'h3);
      wr(REG_MODE, 32'h0000_0400);
      wr(REG_CONST, 32'h0001_1388);
      wr(REG_POS_WRITE, 32'h0);
      mv(2, 1'b1);
      rdc("decimal", REG_POS_READ, 32'h3);
      wr(REG_CONST, 32'hffff_0000);
      wr(REG_POS_WRITE, 32'hffff_fff0);
      mv(1, 1'b1);
      rdc("negative", REG_POS_READ, 32'hffff_ffef);
      test_done();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      test_done();
   end
endmodule
`default_nettype wire
